// *** cbt_core.sv ***
// CAN bit timing, interrupt vector and message word two register block.
`timescale 1ns/100ps
module cbt_core #(
    parameter int NUM_BUFFERS = 16
) (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // Register port
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [15:0]      rdata_o,
    // Receive engine events
    input  wire logic        rx_done_i,
    input  wire logic [4:0]  rx_filter_i,
    input  wire logic [15:0] rx_word_i,
    input  wire logic        rx_extended_i,
    input  wire logic        err_i,
    input  wire logic        wake_i,
    input  wire logic        ovf_i,
    input  wire logic        fifo_af_i,
    // Bus line and timing
    input  wire logic        can_rx_i,
    output logic             sampled_bit_o,
    output logic             sample_valid_o,
    output logic             remote_req_o,
    output logic             irq_o
);
    import cbt_pkg::*;

    logic [15:0] timing_r;
    logic [15:0] msg_r;
    logic [7:0]  quantum_r;
    logic [4:0]  filter_r;
    logic [4:0]  stat_r;
    logic [4:0]  mask_r;
    logic [7:0]  presc_r;
    logic [3:0]  seg_cnt_r;
    cbt_seg_t    seg_r;
    logic        tq_tick;
    logic        at_sample;
    logic [3:0]  prop_len;
    logic [3:0]  ph1_len;
    logic [3:0]  ph2_len;
    logic [6:0]  interrupt_source_code;
    logic [4:0]  ev;

    function automatic logic [3:0] seg_len(input logic [2:0] f);
        return {1'b0, f} + 4'h1;
    endfunction

    assign prop_len = seg_len(timing_r[TIM_PROP_LSB +: 3]);
    assign ph1_len  = seg_len(timing_r[TIM_PH1_LSB +: 3]);
    always_comb begin
        if (timing_r[TIM_SEL_BIT]) begin
            ph2_len = seg_len(timing_r[TIM_PH2_LSB +: 3]);
        end else begin
            ph2_len = (ph1_len > IPT_QUANTA) ? ph1_len : IPT_QUANTA;
        end
    end

    // Software registers.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            timing_r  <= TIM_RESET;
            quantum_r <= QUANTUM_RESET;
            mask_r    <= 5'h00;
        end else if (wr_i) begin
            if (addr_i == ADDR_TIMING) begin
                timing_r <= wdata_i & TIM_WMASK;
            end
            if (addr_i == ADDR_QUANTUM) begin
                quantum_r <= wdata_i[7:0];
            end
            if (addr_i == ADDR_IRQ_MASK) begin
                mask_r <= wdata_i[4:0];
            end
        end
    end

    // Message word: receive fills it, software may overwrite it.
    // Reserved bits are forced to zero by MSG_WMASK on both receive and software write.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            msg_r <= 16'h0000;
        end else if (rx_done_i) begin
            msg_r <= rx_word_i & MSG_WMASK;
        end else if (wr_i && addr_i == ADDR_MSGWORD) begin
            msg_r <= wdata_i & MSG_WMASK;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            remote_req_o <= 1'b0;
        end else begin
            remote_req_o <= rx_extended_i & msg_r[MSG_RTR_BIT];
        end
    end

    // Filter hit number; out-of-range codes are kept off the field.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            filter_r <= 5'h00;
        end else if (rx_done_i && rx_filter_i != 5'h00 && rx_filter_i <= 5'h0f) begin
            filter_r <= rx_filter_i;
        end
    end

    // Sticky status: a read clears, but a new event in the same cycle wins.
    assign ev = {fifo_af_i, ovf_i, wake_i, err_i, rx_done_i};
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_r <= 5'h00;
        end else if (rd_i && addr_i == ADDR_IRQ_STAT) begin
            stat_r <= ev;
        end else begin
            stat_r <= stat_r | ev;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(stat_r & mask_r);
        end
    end

    // Priority: error, wake, overflow, fifo, then buffer of last receive.
    always_comb begin
        if (stat_r[ST_ERR]) begin
            interrupt_source_code = CODE_ERROR;
        end else if (stat_r[ST_WAK]) begin
            interrupt_source_code = CODE_WAKE;
        end else if (stat_r[ST_OVF]) begin
            interrupt_source_code = CODE_OVERFLOW;
        end else if (stat_r[ST_FAF]) begin
            interrupt_source_code = CODE_FIFO_AF;
        end else if (stat_r[ST_RX]) begin
            interrupt_source_code = {2'b00, filter_r};
        end else begin
            interrupt_source_code = CODE_NONE;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            unique case (addr_i)
                ADDR_VECTOR:   rdata_o <= {3'h0, filter_r, 1'b0, interrupt_source_code};
                ADDR_TIMING:   rdata_o <= timing_r;
                ADDR_MSGWORD:  rdata_o <= msg_r;
                ADDR_IRQ_STAT: rdata_o <= {11'h000, stat_r};
                ADDR_IRQ_MASK: rdata_o <= {11'h000, mask_r};
                ADDR_QUANTUM:  rdata_o <= {8'h00, quantum_r};
                default:       rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // Time quantum prescaler: quantum is quantum_r+1 clock cycles.
    // A quantum shortened mid-count ends at once instead of wrapping the counter.
    assign tq_tick = (presc_r >= quantum_r);
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            presc_r <= 8'h00;
        end else begin
            presc_r <= tq_tick ? 8'h00 : presc_r + 8'h01;
        end
    end

    // Bit segment sequencer; the sample point ends phase one.
    // Segments shortened by a write mid-bit end at once, so no bit loses its sample point.
    assign at_sample = tq_tick && seg_r == CBT_PH1 && seg_cnt_r >= ph1_len - 4'h1;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            seg_r     <= CBT_SYNC;
            seg_cnt_r <= 4'h0;
        end else if (tq_tick) begin
            unique case (seg_r)
                CBT_SYNC: begin
                    seg_r     <= CBT_PROP;
                    seg_cnt_r <= 4'h0;
                end
                CBT_PROP: begin
                    if (seg_cnt_r >= prop_len - 4'h1) begin
                        seg_r     <= CBT_PH1;
                        seg_cnt_r <= 4'h0;
                    end else begin
                        seg_cnt_r <= seg_cnt_r + 4'h1;
                    end
                end
                CBT_PH1: begin
                    if (seg_cnt_r >= ph1_len - 4'h1) begin
                        seg_r     <= CBT_PH2;
                        seg_cnt_r <= 4'h0;
                    end else begin
                        seg_cnt_r <= seg_cnt_r + 4'h1;
                    end
                end
                CBT_PH2: begin
                    if (seg_cnt_r >= ph2_len - 4'h1) begin
                        seg_r     <= CBT_SYNC;
                        seg_cnt_r <= 4'h0;
                    end else begin
                        seg_cnt_r <= seg_cnt_r + 4'h1;
                    end
                end
            endcase
        end
    end

    cbt_sampler u_sampler (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .triple_i    (timing_r[TIM_TRIPLE]),
        .tq_tick_i   (tq_tick),
        .at_sample_i (at_sample),
        .rx_i        (can_rx_i),
        .bit_o       (sampled_bit_o),
        .bit_valid_o (sample_valid_o)
    );

    a_filter_range: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        filter_r <= 5'h0f) else $error("filter number out of range");
    a_error_code: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        stat_r[ST_ERR] |-> interrupt_source_code == CODE_ERROR) else $error("error code wrong");
    a_none_code: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        stat_r == 5'h00 |-> interrupt_source_code == CODE_NONE) else $error("idle code wrong");
    a_ph2_prog: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        timing_r[TIM_SEL_BIT] |-> ph2_len == {1'b0, timing_r[10:8]} + 4'h1)
        else $error("phase two length wrong");
    a_seg_bounds: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        prop_len >= 4'h1 && prop_len <= 4'h8 && ph1_len >= 4'h1 && ph1_len <= 4'h8)
        else $error("segment length out of range");
    a_ph2_auto: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !timing_r[TIM_SEL_BIT] |-> ph2_len >= ph1_len && ph2_len >= IPT_QUANTA)
        else $error("automatic phase two too short");
    a_single_sample: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        at_sample && !timing_r[TIM_TRIPLE] |=> sampled_bit_o == $past(can_rx_i))
        else $error("single sample mismatch");
    a_remote_std: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !rx_extended_i |=> !remote_req_o) else $error("remote flag on standard frame");
    a_dlc_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        rx_done_i |=> msg_r[3:0] == $past(rx_word_i[3:0]) && msg_r[15:10] == $past(rx_word_i[15:10]))
        else $error("message word not loaded");
endmodule

// *** cbt_node.sv ***
// Behavioural model of the other nodes on the bus as seen by the timing block.
`timescale 1ns/100ps
module cbt_node (
    // Clock
    input  wire logic        sys_clk_i,
    // Received frames and bus line
    output logic             rx_done_o,
    output logic [4:0]       rx_filter_o,
    output logic [15:0]      rx_word_o,
    output logic             rx_extended_o,
    output logic             can_rx_o
);
    initial begin
        rx_done_o = 1'b0;
        rx_filter_o = 5'h00;
        rx_word_o = 16'h0000;
        rx_extended_o = 1'b0;
        can_rx_o = 1'b1;
    end

    // One received frame; the filter and word fields are scrambled afterwards so stale values are never trusted.
    task automatic send(input logic [4:0] f, input logic [15:0] w, input logic ext);
        @(posedge sys_clk_i);
        rx_done_o <= 1'b1;
        rx_filter_o <= f;
        rx_word_o <= w & 16'hfeef;
        rx_extended_o <= ext;
        @(posedge sys_clk_i);
        rx_done_o <= 1'b0;
        rx_filter_o <= ~f;
        rx_word_o <= ~w;
    endtask

    // Recessive level is 1, so an idle bus reads high.
    task automatic drive(input logic b);
        @(posedge sys_clk_i);
        can_rx_o <= b;
    endtask
endmodule

// *** cbt_pkg.sv ***
// Package with register map, field layout and timing constants for the CAN timing block.
package cbt_pkg;
    // Register offsets on the plain port.
    localparam logic [3:0] ADDR_VECTOR   = 4'h0;
    localparam logic [3:0] ADDR_TIMING   = 4'h1;
    localparam logic [3:0] ADDR_MSGWORD  = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
    localparam logic [3:0] ADDR_QUANTUM  = 4'h5;
    // Timing register fields.
    localparam int TIM_WAKE_BIT  = 14;
    localparam int TIM_PH2_LSB   = 8;
    localparam int TIM_SEL_BIT   = 7;
    localparam int TIM_TRIPLE    = 6;
    localparam int TIM_PH1_LSB   = 3;
    localparam int TIM_PROP_LSB  = 0;
    localparam logic [15:0] TIM_WMASK = 16'h47ff;
    localparam logic [15:0] TIM_RESET = 16'h0000;
    // Message word fields.
    localparam int MSG_RTR_BIT   = 9;
    localparam int MSG_RSVH_BIT  = 8;
    localparam int MSG_RSVL_BIT  = 4;
    localparam logic [15:0] MSG_WMASK = 16'hfe0f;
    // Interrupt source codes.
    localparam logic [6:0] CODE_NONE     = 7'h40;
    localparam logic [6:0] CODE_ERROR    = 7'h41;
    localparam logic [6:0] CODE_WAKE     = 7'h42;
    localparam logic [6:0] CODE_OVERFLOW = 7'h43;
    localparam logic [6:0] CODE_FIFO_AF  = 7'h44;
    // Information processing time in quanta, and reset value of the quantum prescaler register.
    localparam logic [3:0] IPT_QUANTA    = 4'h2;
    localparam logic [7:0] QUANTUM_RESET = 8'h04;
    // Status bits.
    localparam int ST_RX  = 0;
    localparam int ST_ERR = 1;
    localparam int ST_WAK = 2;
    localparam int ST_OVF = 3;
    localparam int ST_FAF = 4;
    typedef enum logic [1:0] {
        CBT_SYNC  = 2'b00,
        CBT_PROP  = 2'b01,
        CBT_PH1   = 2'b10,
        CBT_PH2   = 2'b11
    } cbt_seg_t;
endpackage

// *** cbt_sampler.sv ***
// Sample-point voter: one sample or majority of three consecutive quanta.
`timescale 1ns/100ps
module cbt_sampler (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // Sampling control
    input  wire logic triple_i,
    input  wire logic tq_tick_i,
    input  wire logic at_sample_i,
    input  wire logic rx_i,
    // Result
    output logic      bit_o,
    output logic      bit_valid_o
);
    logic [1:0] hist_r;

    // The two quanta before the sample point feed the vote.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hist_r <= 2'b11;
        end else if (tq_tick_i) begin
            hist_r <= {hist_r[0], rx_i};
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bit_o       <= 1'b1;
            bit_valid_o <= 1'b0;
        end else begin
            bit_valid_o <= at_sample_i;
            if (at_sample_i) begin
                if (triple_i) begin
                    bit_o <= (hist_r[1] & hist_r[0]) | (hist_r[1] & rx_i) | (hist_r[0] & rx_i);
                end else begin
                    bit_o <= rx_i;
                end
            end
        end
    end
endmodule

// *** tb.sv ***
// Self-checking testbench for the CAN timing and message word block.
`timescale 1ns/100ps
module tb;
    import cbt_pkg::*;
    logic        sys_clk_i;
    logic        rst_i;
    logic [3:0]  addr_i;
    logic [15:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [15:0] rdata_o;
    logic        rx_done_i;
    logic [4:0]  rx_filter_i;
    logic [15:0] rx_word_i;
    logic        rx_extended_i;
    logic [3:0]  evs;
    logic        can_rx_i;
    logic        sampled_bit_o;
    logic        sample_valid_o;
    logic        remote_req_o;
    logic        irq_o;
    logic [15:0] v;
    logic [15:0] p;
    int          fail_count;
    int          compares;
    int          cyc;
    logic [15:0] cfg [4] = '{16'h0080, 16'h07bf, 16'h002a, 16'h0300};
    logic [15:0] len [4] = '{16'h0008, 16'h0032, 16'h0020, 16'h000a};

    cbt_core u_dut (.sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .rx_done_i, .rx_filter_i, .rx_word_i, .rx_extended_i, .err_i(evs[0]),
        .wake_i(evs[1]), .ovf_i(evs[2]), .fifo_af_i(evs[3]), .can_rx_i,
        .sampled_bit_o, .sample_valid_o, .remote_req_o, .irq_o);
    cbt_node u_node (.sys_clk_i, .rx_done_o(rx_done_i), .rx_filter_o(rx_filter_i),
        .rx_word_o(rx_word_i), .rx_extended_o(rx_extended_i), .can_rx_o(can_rx_i));

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic conclude();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // The cycle limit is well above the few hundred cycles the sequence needs.
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end

    task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic ev(input logic [3:0] e);
        @(posedge sys_clk_i);
        evs <= e;
        @(posedge sys_clk_i);
        evs <= 4'h0;
    endtask

    // Clocks from one sample pulse to the next, bounded.
    task automatic per(output logic [15:0] n);
        int k;
        k = 0;
        n = 16'h0000;
        do begin
            @(posedge sys_clk_i);
            #1;
            k++;
        end while (sample_valid_o !== 1'b1 && k < 200);
        do begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end while (sample_valid_o !== 1'b1 && n < 16'd200);
    endtask

    initial begin
        rst_i = 1'b1;
        addr_i = 4'h0;
        wdata_i = 16'h0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        evs = 4'h0;
        fail_count = 0;
        compares = 0;
        cyc = 0;
        repeat (12) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd(ADDR_TIMING, v);
        chk("timing reset", v, TIM_RESET);
        rd(ADDR_QUANTUM, v);
        chk("quantum reset", v, {8'h00, QUANTUM_RESET});
        rd(ADDR_VECTOR, v);
        chk("vector reset", v, {9'h000, CODE_NONE});
        rd(4'h9, v);
        chk("unmapped", v, 16'h0000);
        wr(ADDR_VECTOR, 16'hffff);
        rd(ADDR_VECTOR, v);
        chk("vector ro", v, {9'h000, CODE_NONE});
        wr(ADDR_MSGWORD, 16'hffff);
        rd(ADDR_MSGWORD, v);
        chk("word mask", v, MSG_WMASK);
        wr(ADDR_TIMING, 16'hffff);
        rd(ADDR_TIMING, v);
        chk("timing mask", v, TIM_WMASK);
        // A quantum of two clocks keeps the longest bit at fifty clocks.
        wr(ADDR_QUANTUM, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_TIMING, cfg[i]);
            per(p);
            per(p);
            chk("bit period", p, len[i]);
        end
        for (int j = 0; j < 2; j++) begin
            wr(ADDR_TIMING, 16'h0080 | (16'(j) << TIM_TRIPLE));
            u_node.drive(1'b0);
            per(p);
            per(p);
            chk("sampled low", {15'h0000, sampled_bit_o}, 16'h0000);
            u_node.drive(1'b1);
            per(p);
            per(p);
            chk("sampled high", {15'h0000, sampled_bit_o}, 16'h0001);
            // A dip seen only at the sample point is outvoted in triple mode alone.
            repeat (6) @(posedge sys_clk_i);
            u_node.drive(1'b0);
            u_node.drive(1'b1);
            #1;
            chk("glitch valid", {15'h0000, sample_valid_o}, 16'h0001);
            chk("glitch vote", {15'h0000, sampled_bit_o}, 16'(j));
        end
        u_node.send(5'd7, 16'ha60b, 1'b1);
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk("remote ext", {15'h0000, remote_req_o}, 16'h0001);
        rd(ADDR_MSGWORD, v);
        chk("rx word", v, 16'ha60b);
        rd(ADDR_VECTOR, v);
        chk("vector rx", v, 16'h0707);
        u_node.send(5'd15, 16'ha20c, 1'b0);
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk("remote std", {15'h0000, remote_req_o}, 16'h0000);
        rd(ADDR_VECTOR, v);
        chk("vector f15", v, 16'h0f0f);
        rd(ADDR_IRQ_STAT, v);
        chk("status rx", v, 16'h0001);
        rd(ADDR_VECTOR, v);
        chk("vector none", v, 16'h0f00 | 16'(CODE_NONE));
        wr(ADDR_IRQ_MASK, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            ev(4'h1 << i);
            rd(ADDR_VECTOR, v);
            chk("vector code", v, 16'h0f00 | 16'(CODE_ERROR + 7'(i)));
            chk("irq masked", {15'h0000, irq_o}, 16'h0000);
            rd(ADDR_IRQ_STAT, v);
            chk("status event", v, 16'h0001 << (i + 1));
        end
        wr(ADDR_IRQ_MASK, 16'h001f);
        ev(4'hf);
        rd(ADDR_VECTOR, v);
        chk("vector prio", v, 16'h0f00 | 16'(CODE_ERROR));
        chk("irq raised", {15'h0000, irq_o}, 16'h0001);
        rd(ADDR_IRQ_STAT, v);
        chk("status all", v, 16'h001e);
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk("irq cleared", {15'h0000, irq_o}, 16'h0000);
        conclude();
    end
endmodule
